// *** src/spi4_tx_credit_training_ctrl.sv ***
// transmit flow-control: status to credits, calendar polling, training timing
`timescale 1ns/100ps
module spi4_tx_credit_training_ctrl (
  // core clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // status link clock, reset and channel
  input wire logic stat_clk,
  input wire logic stat_rst,
  input wire logic stat_valid,
  input wire logic [1:0] stat_code,
  // configuration writes
  input wire logic cfg_we,
  input wire logic [3:0] cfg_sel,
  input wire logic [9:0] cfg_addr,
  input wire logic [31:0] cfg_data,
  input wire logic cfg_init,
  // datapath handshake and readback select
  input wire logic blk_sent,
  input wire logic [7:0] rd_port,
  // service and training outputs
  output logic init_busy,
  output logic serve_valid,
  output logic [7:0] serve_port,
  output logic [3:0] serve_quota,
  output logic [1:0] serve_status,
  output logic train_active,
  output logic train_pad,
  output logic [3:0] train_pad_bytes,
  // status and readback outputs
  output logic link_framing,
  output logic stat_overrun,
  output logic [15:0] rd_credit,
  output logic [1:0] rd_status
);
  // ***************************************************
  // storage
  // ***************************************************
  logic [tx_credit_pkg::PORT_W-1:0] cal_mem [tx_credit_pkg::CAL_N];
  logic [tx_credit_pkg::CREDIT_W-1:0] credit_mem [tx_credit_pkg::PORT_N];
  logic [tx_credit_pkg::QUOTA_W-1:0] quota_mem [tx_credit_pkg::PORT_N];
  logic [1:0] stat_mem [tx_credit_pkg::PORT_N];
  logic en_mem [tx_credit_pkg::PORT_N];

  stat_xfer_if xfer ();

  status_link_rx link_rx (
    .stat_clk(stat_clk),
    .stat_rst(stat_rst),
    .stat_valid(stat_valid),
    .stat_code(stat_code),
    .xfer(xfer)
  );

  // ***************************************************
  // crossing from the link domain
  // ***************************************************
  logic tog_s1, tog_s2, tog_s3, ovr_s1, ovr_s2;
  logic stat_ev;

  // two flops on toggle and overrun, third only for the toggle edge; code bits are read without flops
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
      ovr_s1 <= 1'b0;
      ovr_s2 <= 1'b0;
    end else begin
      tog_s1 <= xfer.toggle;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
      ovr_s1 <= xfer.overrun;
      ovr_s2 <= ovr_s1;
    end
  end

  assign stat_ev = tog_s2 ^ tog_s3;

  // ***************************************************
  // global settings
  // ***************************************************
  logic [15:0] limit1_reg, limit1_next, limit2_reg, limit2_next;
  logic [31:0] interval_reg, interval_next;
  logic [15:0] repeat_reg, repeat_next;
  logic [9:0] cal_len_reg, cal_len_next;

  // software loads of the global settings
  always_comb begin
    limit1_next = limit1_reg;
    limit2_next = limit2_reg;
    interval_next = interval_reg;
    repeat_next = repeat_reg;
    cal_len_next = cal_len_reg;
    if (cfg_we) begin
      case (cfg_sel)
        tx_credit_pkg::CFG_LIMIT1: limit1_next = cfg_data[15:0];
        tx_credit_pkg::CFG_LIMIT2: limit2_next = cfg_data[15:0];
        tx_credit_pkg::CFG_TRAIN_INTERVAL: interval_next = cfg_data;
        tx_credit_pkg::CFG_TRAIN_REPEAT: repeat_next = cfg_data[15:0];
        tx_credit_pkg::CFG_CAL_LEN: cal_len_next = cfg_data[9:0];
        default: ;
      endcase
    end
  end

  // settings registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      limit1_reg <= tx_credit_pkg::LIMIT_RST;
      limit2_reg <= tx_credit_pkg::LIMIT_RST;
      interval_reg <= tx_credit_pkg::TRAIN_INTERVAL_RST;
      repeat_reg <= tx_credit_pkg::TRAIN_REPEAT_RST;
      cal_len_reg <= tx_credit_pkg::CAL_LEN_RST;
    end else begin
      limit1_reg <= limit1_next;
      limit2_reg <= limit2_next;
      interval_reg <= interval_next;
      repeat_reg <= repeat_next;
      cal_len_reg <= cal_len_next;
    end
  end

  // ***************************************************
  // status slot tracking and update
  // ***************************************************
  tx_credit_pkg::ctrl_state_e state_reg, state_next;
  logic [9:0] slot_reg, slot_next;
  logic pend_reg, pend_next;
  logic [1:0] pend_code_reg, pend_code_next;
  logic [7:0] pend_port_reg, pend_port_next;
  logic framing_reg, framing_next;
  logic [7:0] port_reg, port_next;
  logic [7:0] slot_port;
  logic upd_en;
  logic [7:0] upd_port;
  logic [1:0] upd_code;
  logic [15:0] upd_credit, upd_old;

  assign slot_port = cal_mem[slot_reg];

  // map each non-framing status word to a port; hold it back while that port is served
  always_comb begin
    slot_next = slot_reg;
    pend_next = pend_reg;
    pend_code_next = pend_code_reg;
    pend_port_next = pend_port_reg;
    framing_next = 1'b0;
    upd_en = 1'b0;
    upd_port = slot_port;
    upd_code = xfer.code;
    if (stat_ev) begin
      if (xfer.code == tx_credit_pkg::ST_FRAMING) begin
        slot_next = 10'h000;
        framing_next = 1'b1;
      end else begin
        slot_next = (slot_reg + 10'h001 >= cal_len_reg) ? 10'h000 : slot_reg + 10'h001;
        if (state_reg == tx_credit_pkg::S_SERVE && slot_port == port_reg) begin
          pend_next = 1'b1;
          pend_code_next = xfer.code;
          pend_port_next = port_reg; // port_reg moves on once service ends
        end else begin
          upd_en = (state_reg != tx_credit_pkg::S_INIT);
        end
      end
    end else if (pend_reg && !(state_reg == tx_credit_pkg::S_SERVE && port_reg == pend_port_reg)) begin
      pend_next = 1'b0;
      upd_en = 1'b1;
      upd_port = pend_port_reg;
      upd_code = pend_code_reg;
    end
  end

  // credit loaded by the received status
  always_comb begin
    upd_old = credit_mem[upd_port];
    case (upd_code)
      tx_credit_pkg::ST_STARVING: upd_credit = limit1_reg;
      tx_credit_pkg::ST_HUNGRY: begin
        if (en_mem[upd_port]) begin
          upd_credit = (limit2_reg > upd_old) ? limit2_reg : upd_old;
        end else begin
          upd_credit = limit1_reg;
        end
      end
      default: upd_credit = upd_old;
    endcase
  end

  // slot tracking registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      slot_reg <= 10'h000;
      pend_reg <= 1'b0;
      pend_code_reg <= tx_credit_pkg::STAT_RST;
      pend_port_reg <= 8'h00;
      framing_reg <= 1'b0;
    end else begin
      slot_reg <= slot_next;
      pend_reg <= pend_next;
      pend_code_reg <= pend_code_next;
      pend_port_reg <= pend_port_next;
      framing_reg <= framing_next;
    end
  end

  // ***************************************************
  // polling, service and training control
  // ***************************************************
  logic [9:0] ptr_reg, ptr_next;
  logic [3:0] blk_reg, blk_next;
  logic [31:0] tcnt_reg, tcnt_next;
  logic [15:0] rep_reg, rep_next;
  logic [1:0] burst_reg, burst_next;
  logic pad_reg, pad_next;
  logic [7:0] cal_port;
  logic [15:0] cur_credit, dec_credit;
  logic train_due, dec_en;

  assign cal_port = cal_mem[ptr_reg];
  assign cur_credit = credit_mem[port_reg];
  assign dec_credit = cur_credit - 16'h0001;
  assign train_due = (interval_reg != 32'h00000000) && (repeat_reg != 16'h0000)
                     && (tcnt_reg >= interval_reg);

  // state sequencing
  always_comb begin
    state_next = state_reg;
    ptr_next = ptr_reg;
    port_next = port_reg;
    blk_next = blk_reg;
    rep_next = rep_reg;
    burst_next = burst_reg;
    pad_next = 1'b0;
    dec_en = 1'b0;
    tcnt_next = (state_reg == tx_credit_pkg::S_TRAIN) ? 32'h00000000 :
                (train_due ? tcnt_reg : tcnt_reg + 32'h00000001);
    case (state_reg)
      tx_credit_pkg::S_INIT: begin
        port_next = port_reg + 8'h01; // clearing sweep over all ports
        if (port_reg == tx_credit_pkg::PORT_LAST) begin
          state_next = tx_credit_pkg::S_FETCH;
        end
      end
      tx_credit_pkg::S_FETCH: begin
        if (train_due) begin
          state_next = tx_credit_pkg::S_TRAIN;
          rep_next = repeat_reg;
          burst_next = tx_credit_pkg::TRAIN_BURSTS;
        end else if (cal_len_reg != 10'h000 && !cfg_init) begin
          ptr_next = (ptr_reg + 10'h001 >= cal_len_reg) ? 10'h000 : ptr_reg + 10'h001;
          port_next = cal_port;
          blk_next = quota_mem[cal_port];
          if (quota_mem[cal_port] != 4'h0 && credit_mem[cal_port] >= {12'h000, quota_mem[cal_port]}) begin
            state_next = tx_credit_pkg::S_SERVE;
          end
        end
      end
      tx_credit_pkg::S_SERVE: begin
        if (blk_sent) begin
          dec_en = 1'b1;
          blk_next = blk_reg - 4'h1;
          if (blk_reg == 4'h1 || dec_credit == 16'h0000) begin
            state_next = tx_credit_pkg::S_FETCH;
          end else if (dec_credit < {12'h000, quota_mem[port_reg]}) begin
            state_next = tx_credit_pkg::S_FETCH;
          end
        end
      end
      tx_credit_pkg::S_TRAIN: begin
        burst_next = burst_reg - 2'h1;
        pad_next = (burst_reg == 2'h2) && (tx_credit_pkg::TRAIN_PAD_BYTES != 4'h0);
        if (burst_reg == 2'h1) begin
          burst_next = tx_credit_pkg::TRAIN_BURSTS;
          rep_next = rep_reg - 16'h0001;
          if (rep_reg == 16'h0001) begin
            state_next = tx_credit_pkg::S_FETCH;
          end
        end
      end
      default: state_next = tx_credit_pkg::S_INIT;
    endcase
  end

  // control registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= tx_credit_pkg::S_INIT;
      ptr_reg <= 10'h000;
      port_reg <= 8'h00;
      blk_reg <= 4'h0;
      tcnt_reg <= 32'h00000000;
      rep_reg <= 16'h0000;
      burst_reg <= 2'h0;
      pad_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ptr_reg <= ptr_next;
      port_reg <= port_next;
      blk_reg <= blk_next;
      tcnt_reg <= tcnt_next;
      rep_reg <= rep_next;
      burst_reg <= burst_next;
      pad_reg <= pad_next;
    end
  end

  // ***************************************************
  // descriptor and calendar memory writes
  // ***************************************************
  logic init_w, cfg_port_w;
  logic [7:0] cfg_port;

  assign init_w = (state_reg == tx_credit_pkg::S_INIT);
  assign cfg_port = cfg_addr[7:0];
  assign cfg_port_w = cfg_we && !init_w;

  // one writer per array; sweep, software and status share the second port
  always_ff @(posedge clock) begin
    if (cfg_we && cfg_init && cfg_sel == tx_credit_pkg::CFG_CAL_ENTRY) begin
      cal_mem[cfg_addr] <= cfg_data[7:0];
    end
    if (dec_en) begin
      credit_mem[port_reg] <= dec_credit;
    end
    if (init_w) begin
      credit_mem[port_reg] <= tx_credit_pkg::CREDIT_RST;
      quota_mem[port_reg] <= tx_credit_pkg::QUOTA_RST;
      stat_mem[port_reg] <= tx_credit_pkg::STAT_RST;
      en_mem[port_reg] <= 1'b0;
    end else begin
      if (upd_en) begin
        credit_mem[upd_port] <= upd_credit;
        stat_mem[upd_port] <= upd_code;
      end
      if (cfg_port_w && cfg_sel == tx_credit_pkg::CFG_QUOTA) begin
        quota_mem[cfg_port] <= cfg_data[3:0];
      end
      if (cfg_port_w && cfg_sel == tx_credit_pkg::CFG_SECOND_EN) begin
        en_mem[cfg_port] <= cfg_data[0];
      end
      if (cfg_port_w && cfg_init && cfg_sel == tx_credit_pkg::CFG_CREDIT) begin
        credit_mem[cfg_port] <= cfg_data[15:0];
      end
      if (cfg_port_w && cfg_init && cfg_sel == tx_credit_pkg::CFG_STATUS) begin
        stat_mem[cfg_port] <= cfg_data[1:0];
      end
    end
  end

  // ***************************************************
  // registered outputs
  // ***************************************************
  logic [15:0] rd_credit_reg;
  logic [1:0] rd_status_reg;
  logic [3:0] quota_out_reg;
  logic [1:0] status_out_reg;

  // readback and service detail sampled every cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_credit_reg <= tx_credit_pkg::CREDIT_RST;
      rd_status_reg <= tx_credit_pkg::STAT_RST;
      quota_out_reg <= tx_credit_pkg::QUOTA_RST;
      status_out_reg <= tx_credit_pkg::STAT_RST;
    end else begin
      rd_credit_reg <= init_w ? tx_credit_pkg::CREDIT_RST : credit_mem[rd_port]; // entries unwritten during sweep
      rd_status_reg <= init_w ? tx_credit_pkg::STAT_RST : stat_mem[rd_port];
      quota_out_reg <= init_w ? tx_credit_pkg::QUOTA_RST : quota_mem[port_next];
      status_out_reg <= init_w ? tx_credit_pkg::STAT_RST : stat_mem[port_next];
    end
  end

  assign init_busy = state_reg[0];
  assign serve_valid = state_reg[2];
  assign train_active = state_reg[3];
  assign serve_port = port_reg;
  assign serve_quota = quota_out_reg;
  assign serve_status = status_out_reg;
  assign train_pad = pad_reg;
  assign train_pad_bytes = tx_credit_pkg::TRAIN_PAD_BYTES;
  assign link_framing = framing_reg;
  assign stat_overrun = ovr_s2;
  assign rd_credit = rd_credit_reg;
  assign rd_status = rd_status_reg;
endmodule : spi4_tx_credit_training_ctrl

// *** src/tx_credit_pkg.sv ***
// constants and types shared by the transmit credit and training logic
package tx_credit_pkg;
  // ***************************************************
  // sizes
  // ***************************************************
  localparam int PORT_W = 8;
  localparam int PORT_N = 256;
  localparam int CAL_W = 10;
  localparam int CAL_N = 1024;
  localparam int CREDIT_W = 16;
  localparam int QUOTA_W = 4;
  localparam logic [PORT_W-1:0] PORT_LAST = 8'hFF;
  // ***************************************************
  // received status codes
  // ***************************************************
  localparam logic [1:0] ST_STARVING = 2'h0;
  localparam logic [1:0] ST_HUNGRY = 2'h1;
  localparam logic [1:0] ST_SATISFIED = 2'h2;
  localparam logic [1:0] ST_FRAMING = 2'h3;
  // ***************************************************
  // configuration write selects
  // ***************************************************
  localparam logic [3:0] CFG_LIMIT1 = 4'h0;
  localparam logic [3:0] CFG_LIMIT2 = 4'h1;
  localparam logic [3:0] CFG_TRAIN_INTERVAL = 4'h2;
  localparam logic [3:0] CFG_TRAIN_REPEAT = 4'h3;
  localparam logic [3:0] CFG_CAL_LEN = 4'h4;
  localparam logic [3:0] CFG_CAL_ENTRY = 4'h5;
  localparam logic [3:0] CFG_QUOTA = 4'h6;
  localparam logic [3:0] CFG_SECOND_EN = 4'h7;
  localparam logic [3:0] CFG_CREDIT = 4'h8;
  localparam logic [3:0] CFG_STATUS = 4'h9;
  // ***************************************************
  // reset values
  // ***************************************************
  localparam logic [15:0] LIMIT_RST = 16'h0000;
  localparam logic [31:0] TRAIN_INTERVAL_RST = 32'h00000000;
  localparam logic [15:0] TRAIN_REPEAT_RST = 16'h0000;
  localparam logic [CAL_W-1:0] CAL_LEN_RST = 10'h000;
  localparam logic [1:0] STAT_RST = ST_SATISFIED;
  localparam logic [CREDIT_W-1:0] CREDIT_RST = 16'h0000;
  localparam logic [QUOTA_W-1:0] QUOTA_RST = 4'h0;
  // ***************************************************
  // timing and training shape
  // ***************************************************
  localparam int BURST_BYTES = 16;
  localparam int TRAIN_PATTERN_BYTES = 40;
  localparam int TRAIN_BURSTS_I = (TRAIN_PATTERN_BYTES + BURST_BYTES - 1) / BURST_BYTES;
  localparam logic [1:0] TRAIN_BURSTS = 2'(TRAIN_BURSTS_I);
  localparam logic [3:0] TRAIN_PAD_BYTES = 4'(TRAIN_BURSTS_I * BURST_BYTES - TRAIN_PATTERN_BYTES);
  localparam logic [3:0] STAT_MIN_GAP = 4'h8;
  // ***************************************************
  // control states
  // ***************************************************
  typedef enum logic [3:0] {
    S_INIT = 4'b0001,
    S_FETCH = 4'b0010,
    S_SERVE = 4'b0100,
    S_TRAIN = 4'b1000
  } ctrl_state_e;
endpackage : tx_credit_pkg

// *** src/stat_xfer_if.sv ***
// status word crossing from the link clock to the core clock
`timescale 1ns/100ps
interface stat_xfer_if;
  logic toggle;
  logic [1:0] code;
  logic overrun;
  modport link (output toggle, output code, output overrun);
  modport core (input toggle, input code, input overrun);
endinterface : stat_xfer_if

// *** src/status_link_rx.sv ***
// status channel capture on the link clock with spacing check
`timescale 1ns/100ps
module status_link_rx (
  // link clock and its reset
  input wire logic stat_clk,
  input wire logic stat_rst,
  // status channel
  input wire logic stat_valid,
  input wire logic [1:0] stat_code,
  // crossing toward the core
  stat_xfer_if.link xfer
);
  logic [3:0] gap_reg, gap_next;
  logic tog_reg, tog_next;
  logic [1:0] code_reg, code_next;
  logic ovr_reg, ovr_next;

  // accept a word only when eight link cycles have passed since the last one
  always_comb begin
    gap_next = (gap_reg == tx_credit_pkg::STAT_MIN_GAP) ? gap_reg : gap_reg + 4'h1;
    tog_next = tog_reg;
    code_next = code_reg;
    ovr_next = ovr_reg;
    if (stat_valid) begin
      if (gap_reg == tx_credit_pkg::STAT_MIN_GAP) begin
        gap_next = 4'h1;
        tog_next = ~tog_reg;
        code_next = stat_code;
      end else begin
        ovr_next = 1'b1; // too close: dropped and flagged
      end
    end
  end

  // link-domain registers
  always_ff @(posedge stat_clk) begin
    if (stat_rst) begin
      gap_reg <= tx_credit_pkg::STAT_MIN_GAP;
      tog_reg <= 1'b0;
      code_reg <= tx_credit_pkg::ST_FRAMING;
      ovr_reg <= 1'b0;
    end else begin
      gap_reg <= gap_next;
      tog_reg <= tog_next;
      code_reg <= code_next;
      ovr_reg <= ovr_next;
    end
  end

  assign xfer.toggle = tog_reg;
  assign xfer.code = code_reg;
  assign xfer.overrun = ovr_reg;
endmodule : status_link_rx

// *** sim/spi4_tx_credit_training_ctrl_sva.sv ***
// concurrent checks on the credit and training block ports
`timescale 1ns/100ps
module spi4_tx_credit_training_ctrl_chk (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // service side
  input wire logic blk_sent,
  input wire logic init_busy,
  input wire logic serve_valid,
  input wire logic [3:0] serve_quota,
  input wire logic [1:0] serve_status,
  input wire logic [1:0] rd_status,
  // training and link status
  input wire logic train_active,
  input wire logic train_pad,
  input wire logic [3:0] train_pad_bytes,
  input wire logic link_framing,
  input wire logic stat_overrun
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [3:0] sent_reg;
  logic [3:0] sent_next;
  // ***************
  // blocks sent in the current service
  // ***************
  always_comb begin
    sent_next = (sys_rst || !serve_valid) ? 4'h0 : sent_reg + 4'(blk_sent);
  end
  always_ff @(posedge clock) begin
    sent_reg <= sent_next;
  end
  // ***************
  // properties
  // ***************
  AST_SERVE_QUOTA: assert property ($rose(serve_valid) |-> serve_quota != 4'h0)
    else $error("service started with zero quota");
  AST_SERVE_COUNT: assert property (serve_valid |-> sent_reg < serve_quota)
    else $error("more blocks than quota in one service");
  AST_SERVE_END: assert property (serve_valid && blk_sent && sent_reg == serve_quota - 4'h1 |=> !serve_valid)
    else $error("service did not end at quota");
  AST_NO_CODE3: assert property (serve_status != 2'h3 && rd_status != 2'h3)
    else $error("framing code stored as port state");
  AST_FRAMING_PULSE: assert property (link_framing |=> !link_framing)
    else $error("framing flag longer than one cycle");
  AST_OVERRUN_STICKY: assert property (stat_overrun |=> stat_overrun)
    else $error("overrun flag dropped");
  AST_PAD_SHAPE: assert property ($rose(train_active) |-> !train_pad [*2] ##1 train_pad ##1 !train_pad)
    else $error("idle pad not in third pattern cycle");
  AST_PAD_IN_TRAIN: assert property (train_pad |-> train_active && train_pad_bytes == 4'h8)
    else $error("pad outside training or wrong pad count");
  AST_INIT_QUIET: assert property (init_busy |-> !serve_valid && !train_active)
    else $error("service or training during init sweep");
  // main scenarios
  CV_SERVE: cover property ($rose(serve_valid));
  CV_TRAIN: cover property (train_pad);
  CV_OVERRUN: cover property ($rose(stat_overrun));
endmodule : spi4_tx_credit_training_ctrl_chk
bind spi4_tx_credit_training_ctrl spi4_tx_credit_training_ctrl_chk i_chk (.*);

// *** sim/far_status_src.sv ***
// far-end receiver model sending status words on the link clock
`timescale 1ns/100ps
module far_status_src (
  // link clock and reset
  input wire logic stat_clk,
  input wire logic stat_rst,
  // status channel
  output logic stat_valid,
  output logic [1:0] stat_code
);
  // ***************
  // word sender
  // ***************
  // waits gap link cycles, sends one word; idle code line shows the inverse
  task automatic send(input logic [1:0] code, input int gap);
    while (stat_rst) @(posedge stat_clk);
    repeat (gap) @(posedge stat_clk);
    stat_valid <= 1'b1;
    stat_code <= code;
    @(posedge stat_clk);
    stat_valid <= 1'b0;
    stat_code <= ~code;
  endtask : send
  initial begin
    stat_valid = 1'b0;
    stat_code = 2'h0;
  end
endmodule : far_status_src

// *** sim/testbench.sv ***
// self-checking bench for the transmit credit and training block
`timescale 1ns/100ps
module testbench;
  logic clock = 1'b0;
  logic stat_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic stat_rst = 1'b1;
  logic cfg_we = 1'b0;
  logic [3:0] cfg_sel = 4'h0;
  logic [9:0] cfg_addr = 10'h000;
  logic [31:0] cfg_data = 32'h00000000;
  logic cfg_init = 1'b1;
  logic blk_sent = 1'b0;
  logic [7:0] rd_port = 8'h00;
  logic stat_valid, init_busy, serve_valid, train_active, train_pad, link_framing, stat_overrun;
  logic [1:0] stat_code, serve_status, rd_status, c;
  logic [3:0] serve_quota, train_pad_bytes;
  logic [7:0] serve_port;
  logic [15:0] rd_credit, lim1, lim2;
  logic [15:0] cred [1:4];
  logic [1:0] stat [1:4];
  logic en [1:4];
  logic [3:0] qt [1:4];
  int seed = 32'h5FDF26B0;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int i, k, n, p;
  // clocks, link clock offset in phase
  always #20 clock = ~clock;
  initial begin
    #7;
    forever #15 stat_clk = ~stat_clk;
  end
  spi4_tx_credit_training_ctrl i_spi4_tx_credit_training_ctrl (.*);
  far_status_src i_far_status_src (.*);
  // ***************
  // tasks and expectation
  // ***************
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic wcfg(input logic [3:0] s, input logic [9:0] a, input logic [31:0] d);
    @(negedge clock);
    cfg_we = 1'b1;
    cfg_sel = s;
    cfg_addr = a;
    cfg_data = d;
    @(negedge clock);
    cfg_we = 1'b0;
  endtask : wcfg
  task automatic rd(input int pt);
    @(negedge clock);
    rd_port = 8'(pt);
    repeat (2) @(negedge clock);
  endtask : rd
  task automatic word(input logic [1:0] cd, input int gap);
    i_far_status_src.send(cd, gap);
    repeat (8) @(negedge clock);
  endtask : word
  task automatic quiet(input string name);
    n = 0;
    repeat (120) begin
      @(negedge clock);
      n += int'(train_active === 1'b1);
    end
    check(name, 16'h0000, 16'(n));
  endtask : quiet
  function automatic logic [15:0] nxt(input logic [1:0] cd, input logic e, input logic [15:0] old);
    case (cd)
      2'h0: nxt = lim1;
      2'h1: nxt = e ? ((lim2 > old) ? lim2 : old) : lim1;
      default: nxt = old;
    endcase
  endfunction : nxt
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  // hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      summarize();
    end
  end
  // ***************
  // main sequence
  // ***************
  initial begin
    lim1 = 16'h0000;
    lim2 = 16'h0000;
    repeat (20) @(negedge clock);
    check("rd_status", 16'h0002, {14'h0, rd_status});
    sys_rst = 1'b0;
    stat_rst = 1'b0;
    n = 0;
    while (init_busy !== 1'b0 && n < 400) begin
      @(negedge clock);
      n++;
    end
    check("init_busy", 16'h0000, {15'h0, init_busy});
    wcfg(tx_credit_pkg::CFG_CAL_LEN, 10'h000, 32'h4);
    for (p = 1; p <= 4; p++) begin
      en[p] = 1'($random(seed));
      wcfg(tx_credit_pkg::CFG_CAL_ENTRY, 10'(p - 1), 32'(p));
      wcfg(tx_credit_pkg::CFG_SECOND_EN, 10'(p), 32'(en[p]));
      qt[p] = 4'(1 + {$random(seed)} % 3);
      wcfg(tx_credit_pkg::CFG_QUOTA, 10'(p), 32'(qt[p]));
      cred[p] = 16'h0000;
      stat[p] = 2'h2;
    end
    wcfg(tx_credit_pkg::CFG_CREDIT, 10'h003, 32'h7);
    cred[3] = 16'h0007;
    wcfg(tx_credit_pkg::CFG_STATUS, 10'h004, 32'h1);
    stat[4] = 2'h1;
    word(2'h3, 9);
    word(2'h0, 9);
    cred[1] = nxt(2'h0, en[1], cred[1]);
    stat[1] = 2'h0;
    lim1 = 16'(1 + {$random(seed)} % 40);
    lim2 = 16'(1 + {$random(seed)} % 40);
    wcfg(tx_credit_pkg::CFG_LIMIT1, 10'h000, 32'(lim1));
    wcfg(tx_credit_pkg::CFG_LIMIT2, 10'h000, 32'(lim2));
    for (k = 0; k < 6; k++) begin
      for (p = 1; p <= 4; p++) begin
        rd(p);
        check("rd_credit", cred[p], rd_credit);
        check("rd_status", {14'h0, stat[p]}, {14'h0, rd_status});
      end
      word(2'h3, 9);
      for (i = 0; i < 5; i++) begin
        p = 1 + i % 4;
        c = 2'({$random(seed)} % 3);
        word(c, 9 + {$random(seed)} % 4);
        cred[p] = nxt(c, en[p], cred[p]);
        stat[p] = c;
      end
    end
    // polling with random block traffic and fresh status
    cfg_init = 1'b0;
    fork
      repeat (400) begin
        @(negedge clock);
        if (serve_valid === 1'b1) begin
          check("serve_quota", {12'h0, qt[serve_port]}, {12'h0, serve_quota});
        end
        blk_sent = 1'($random(seed));
      end
      repeat (20) word(2'({$random(seed)} % 3), 9);
    join
    // keep blocks flowing so no service stalls the training entry
    blk_sent = 1'b1;
    wcfg(tx_credit_pkg::CFG_TRAIN_REPEAT, 10'h000, 32'h2);
    quiet("train_off_interval");
    wcfg(tx_credit_pkg::CFG_TRAIN_INTERVAL, 10'h000, 32'h1E);
    n = 0;
    while (train_active !== 1'b1 && n < 300) begin
      @(negedge clock);
      n++;
    end
    n = 0;
    k = 0;
    while (train_active === 1'b1 && n < 100) begin
      k += int'(train_pad === 1'b1);
      n++;
      @(negedge clock);
    end
    check("train_cycles", 16'h0006, 16'(n));
    check("train_pads", 16'h0002, 16'(k));
    wcfg(tx_credit_pkg::CFG_TRAIN_REPEAT, 10'h000, 32'h0);
    repeat (10) @(negedge clock);
    quiet("train_off_repeat");
    blk_sent = 1'b0;
    check("stat_overrun", 16'h0000, {15'h0, stat_overrun});
    i_far_status_src.send(2'h2, 9);
    i_far_status_src.send(2'h2, 3);
    repeat (10) @(negedge clock);
    check("stat_overrun", 16'h0001, {15'h0, stat_overrun});
    summarize();
  end
endmodule : testbench
